// >>> rtl/rac_defines.svh
// Constants of the radiometer averaging control block
`ifndef RAC_DEFINES_SVH
`define RAC_DEFINES_SVH
`define RAC_ADC_W        13
`define RAC_ACC_W        21
`define RAC_EXP_MAX      4'h8
`define RAC_GAIN_MAX     4'h9
`define RAC_OFS_RST      13'h0000
`define RAC_GAIN_RST     4'h0
`define RAC_EXP_RST      4'h0
`define RAC_MID_SCALE    13'h1000
`define RAC_FIFO_DEPTH   8
`define RAC_NV_W         24
`define RAC_CLK_HZ       250000000
`define RAC_TONE_HZ      22000
`define RAC_TONE_HALF    ((`RAC_CLK_HZ / `RAC_TONE_HZ) / 2)
`define RAC_REG_OFS      4'h0
`define RAC_REG_GAIN     4'h1
`define RAC_REG_EXP      4'h2
`define RAC_REG_SEL      4'h3
`define RAC_REG_CMD      4'h4
`define RAC_REG_STAT     4'h5
`define RAC_REG_MEAS     4'h6
`define RAC_CMD_CAL      0
`define RAC_CMD_SAVE     1
`define RAC_SEL_POL      0
`define RAC_SEL_BAND     1
`endif

// >>> rtl/rac_pkg.sv
// Types of the radiometer averaging control block
package rac_pkg;
    typedef struct packed {
        logic [12:0] offset;
        logic [3:0]  gain;
        logic [3:0]  exponent;
        logic        polarization_select;
        logic        band;
    } rac_param_t;
    typedef struct packed {
        logic        valid;
        logic [12:0] sample;
    } rac_sample_t;
    typedef enum logic [1:0] {
        RAC_IDLE    = 2'b00,
        RAC_LOAD    = 2'b01,
        RAC_RUN     = 2'b10,
        RAC_CAL     = 2'b11
    } rac_state_t;
endpackage

// >>> rtl/rac_fifo.sv
// Word FIFO with valid and ready on both sides
`timescale 1ns/100ps
module rac_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0]    wp_q, wp_d, rp_q, rp_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH)) && ce;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rp_q];

    always_comb begin
        push  = in_valid && in_ready;
        pop   = out_valid && out_ready && ce;
        mem_d = mem_q;
        wp_d  = wp_q;
        rp_d  = rp_q;
        cnt_d = cnt_q;
        if (push) begin
            mem_d[wp_q] = in_data;
            wp_d        = (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + AW'(1);
        end
        if (pop) begin
            rp_d = (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + AW'(1);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + (AW+1)'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (ce) begin
            wp_q  <= wp_d;
            rp_q  <= rp_d;
            cnt_q <= cnt_d;
            mem_q <= mem_d;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!nrst)
        cnt_q <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule

// >>> rtl/rac_tone.sv
// Band tone generator for the converter feed line
`timescale 1ns/100ps
`include "rac_defines.svh"
module rac_tone (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    // Control and line
    input  wire logic enable,
    output logic      tone
);
    localparam logic [12:0] HALF = 13'(`RAC_TONE_HALF - 1);
    logic [12:0] div_q, div_d;
    logic        tone_q, tone_d;

    assign tone = tone_q;

    always_comb begin
        div_d  = div_q;
        tone_d = tone_q;
        if (!enable) begin
            div_d  = '0;
            tone_d = 1'b0;
        end else if (div_q == HALF) begin
            div_d  = '0;
            tone_d = !tone_q;
        end else begin
            div_d = div_q + 13'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            div_q  <= '0;
            tone_q <= 1'b0;
        end else if (ce) begin
            div_q  <= div_d;
            tone_q <= tone_d;
        end
    end

    tone_off_low_a: assert property (@(posedge clk) disable iff (!nrst)
        ce && !enable |=> !tone) else $error("tone active in low band");
endmodule

// >>> rtl/rac_top.sv
// Radiometer parameter store, baseline offset and moving-average logic
`timescale 1ns/100ps
`include "rac_defines.svh"
module rac_top
    import rac_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        CLK_SYS,
    input  wire logic        NRST,
    input  wire logic        CE,
    // Register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [31:0]      RDATA,
    // Converter samples
    input  wire logic        ADC_VALID,
    output logic             ADC_READY,
    input  wire logic [12:0] ADC_DATA,
    // Measurement output
    output logic             MEAS_VALID,
    output logic [12:0]      MEAS_DATA,
    // Analogue controls
    output rac_pkg::rac_param_t PARAM,
    output logic             POL_VERTICAL,
    output logic             TONE_22K,
    // Non-volatile storage
    output logic             NV_WRITE,
    output logic [23:0]      NV_WDATA,
    input  wire logic        NV_VALID,
    input  wire logic [23:0] NV_RDATA
);
    import rac_pkg::*;

    function automatic logic [12:0] sat_sub(input logic [12:0] a, input logic [12:0] b);
        sat_sub = (a > b) ? a - b : 13'h0000;
    endfunction

    rac_param_t  par_q, par_d;
    rac_state_t  st_q, st_d;
    logic [255:0][12:0] win_q, win_d;
    logic [7:0]  wp_q, wp_d;
    logic [8:0]  fill_q, fill_d;
    logic [20:0] acc_q, acc_d;
    logic [12:0] meas_q, meas_d;
    logic        mv_q, mv_d;
    logic [31:0] rdata_q, rdata_d;
    logic        nvw_q, nvw_d;
    logic        restored_q, restored_d;
    logic        fifo_valid, fifo_ready;
    logic [12:0] fifo_data, smp;
    logic [8:0]  win_len;

    rac_fifo #(.WIDTH(`RAC_ADC_W), .DEPTH(`RAC_FIFO_DEPTH)) u_fifo (
        .clk       (CLK_SYS),
        .nrst      (NRST),
        .ce        (CE),
        .in_valid  (ADC_VALID),
        .in_ready  (ADC_READY),
        .in_data   (ADC_DATA),
        .out_valid (fifo_valid),
        .out_ready (fifo_ready),
        .out_data  (fifo_data)
    );

    rac_tone u_tone (
        .clk    (CLK_SYS),
        .nrst   (NRST),
        .ce     (CE),
        .enable (par_q.band),
        .tone   (TONE_22K)
    );

    assign PARAM        = par_q;
    assign POL_VERTICAL = par_q.polarization_select;
    assign MEAS_VALID   = mv_q;
    assign MEAS_DATA    = meas_q;
    assign RDATA        = rdata_q;
    assign NV_WRITE     = nvw_q;
    assign NV_WDATA     = {1'b0, par_q};
    assign fifo_ready   = (st_q == RAC_RUN) || (st_q == RAC_CAL);
    assign win_len      = 9'h001 << par_q.exponent;
    assign smp          = sat_sub(fifo_data, par_q.offset);

    // Parameter and command decode
    always_comb begin
        par_d      = par_q;
        nvw_d      = 1'b0;
        restored_d = restored_q;
        rdata_d    = 32'h0000_0000;
        if (!restored_q && NV_VALID) begin
            par_d      = rac_param_t'(NV_RDATA[22:0]);
            restored_d = 1'b1;
            if (par_d.exponent > `RAC_EXP_MAX) begin
                par_d.exponent = `RAC_EXP_MAX;
            end
        end
        if (WR) begin
            case (ADDR)
                `RAC_REG_OFS:  par_d.offset = WDATA[12:0];
                `RAC_REG_GAIN: par_d.gain = (WDATA[3:0] > `RAC_GAIN_MAX) ? `RAC_GAIN_MAX : WDATA[3:0];
                `RAC_REG_EXP:  par_d.exponent = (WDATA[3:0] > `RAC_EXP_MAX) ? `RAC_EXP_MAX : WDATA[3:0];
                `RAC_REG_SEL: begin
                    par_d.polarization_select  = WDATA[`RAC_SEL_POL];
                    par_d.band = WDATA[`RAC_SEL_BAND];
                end
                `RAC_REG_CMD:  nvw_d = WDATA[`RAC_CMD_SAVE];
                default: ;
            endcase
        end
        if (st_q == RAC_CAL && fifo_valid) begin
            par_d.offset = (fifo_data > `RAC_MID_SCALE) ? fifo_data - `RAC_MID_SCALE : 13'h0000;
        end
        if (RD) begin
            case (ADDR)
                `RAC_REG_OFS:  rdata_d = {19'h0_0000, par_q.offset};
                `RAC_REG_GAIN: rdata_d = {28'h000_0000, par_q.gain};
                `RAC_REG_EXP:  rdata_d = {28'h000_0000, par_q.exponent};
                `RAC_REG_SEL:  rdata_d = {30'h0000_0000, par_q.band, par_q.polarization_select};
                `RAC_REG_STAT: rdata_d = {21'h00_0000, restored_q, (st_q == RAC_CAL), fill_q};
                `RAC_REG_MEAS: rdata_d = {19'h0_0000, meas_q};
                default:       rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // Averaging state machine
    always_comb begin
        st_d   = st_q;
        win_d  = win_q;
        wp_d   = wp_q;
        fill_d = fill_q;
        acc_d  = acc_q;
        meas_d = meas_q;
        mv_d   = 1'b0;
        case (st_q)
            RAC_IDLE: st_d = RAC_LOAD;
            RAC_LOAD: begin
                wp_d   = 8'h00;
                fill_d = 9'h000;
                acc_d  = 21'h00_0000;
                st_d   = RAC_RUN;
            end
            RAC_RUN: begin
                if (fifo_valid) begin
                    win_d[wp_q] = smp;
                    wp_d        = (9'(wp_q) + 9'h001 == win_len) ? 8'h00 : wp_q + 8'h01;
                    if (fill_q == win_len) begin
                        acc_d = acc_q + 21'(smp) - 21'(win_q[wp_q]);
                        meas_d = 13'((acc_q + 21'(smp) - 21'(win_q[wp_q])) >> par_q.exponent);
                        mv_d   = 1'b1;
                    end else begin
                        acc_d  = acc_q + 21'(smp);
                        fill_d = fill_q + 9'h001;
                        if (fill_q + 9'h001 == win_len) begin
                            meas_d = 13'((acc_q + 21'(smp)) >> par_q.exponent);
                            mv_d   = 1'b1;
                        end
                    end
                end
            end
            RAC_CAL: if (fifo_valid) st_d = RAC_LOAD;
            default: st_d = RAC_IDLE;
        endcase
        if (WR && ADDR == `RAC_REG_CMD && WDATA[`RAC_CMD_CAL]) begin
            st_d = RAC_CAL;
        end
        if (par_d.exponent != par_q.exponent) begin
            st_d   = RAC_LOAD;
            wp_d   = 8'h00;
            fill_d = 9'h000;
            acc_d  = 21'h00_0000;
            mv_d   = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!NRST) begin
            par_q      <= '{offset: `RAC_OFS_RST, gain: `RAC_GAIN_RST, exponent: `RAC_EXP_RST,
                            polarization_select: 1'b0, band: 1'b0};
            st_q       <= RAC_IDLE;
            win_q      <= '0;
            wp_q       <= 8'h00;
            fill_q     <= 9'h000;
            acc_q      <= 21'h00_0000;
            meas_q     <= 13'h0000;
            mv_q       <= 1'b0;
            rdata_q    <= 32'h0000_0000;
            nvw_q      <= 1'b0;
            restored_q <= 1'b0;
        end else if (CE) begin
            par_q      <= par_d;
            st_q       <= st_d;
            win_q      <= win_d;
            wp_q       <= wp_d;
            fill_q     <= fill_d;
            acc_q      <= acc_d;
            meas_q     <= meas_d;
            mv_q       <= mv_d;
            rdata_q    <= rdata_d;
            nvw_q      <= nvw_d;
            restored_q <= restored_d;
        end
    end

    sequence save_cmd_s;
        CE && WR && ADDR == `RAC_REG_CMD && WDATA[`RAC_CMD_SAVE];
    endsequence

    nv_save_only_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        NV_WRITE |-> $past(WR) && $past(ADDR) == `RAC_REG_CMD) else $error("storage write without save");
    nv_save_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        save_cmd_s |=> NV_WRITE) else $error("save command not written");
    exp_bound_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        par_q.exponent <= `RAC_EXP_MAX) else $error("exponent above 8");
    gain_bound_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        par_q.gain <= `RAC_GAIN_MAX) else $error("gain above range");
    pol_follow_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && WR && ADDR == `RAC_REG_SEL |=> POL_VERTICAL == $past(WDATA[0])) else $error("pol not set");
    exp_restart_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        CE && $changed(par_q.exponent) |-> st_q == RAC_LOAD) else $error("window not restarted");
    fill_bound_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        fill_q <= win_len) else $error("window overfilled");
    cal_end_a: assert property (@(posedge CLK_SYS) disable iff (!NRST)
        st_q == RAC_CAL && fifo_valid && CE && !WR |=> st_q == RAC_LOAD) else $error("calibration stuck");
endmodule

// >>> testbench/rac_nv_model.sv
// Non-volatile parameter storage model on the far side of the block
`timescale 1ns/100ps
module rac_nv_model #(
    parameter logic [23:0] INIT = 24'h00_0000
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        nv_write,
    input  wire logic [23:0] nv_wdata,
    output logic             nv_valid,
    output logic [23:0]      nv_rdata
);
    logic [23:0] mem;
    logic [1:0]  cnt;
    initial mem = INIT;
    initial cnt = 2'h0;
    // content survives reset, changed by store strobe only
    always @(posedge clk) begin
        if (nv_write === 1'b1) mem <= nv_wdata;
        if (!nrst) cnt <= 2'h0;
        else if (cnt != 2'h3) cnt <= cnt + 2'h1;
    end
    // word offered once after reset, inverted while idle
    assign nv_valid = (cnt == 2'h2);
    assign nv_rdata = nv_valid ? mem : ~mem;
endmodule

// >>> testbench/rac_tb_top.sv
// Self-checking bench of the radiometer averaging control block
`timescale 1ns/100ps
`include "rac_defines.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module rac_tb_top;
    import rac_pkg::*;
    localparam logic [23:0] NV_INIT = {1'b0, 13'h0100, 4'h3, 4'h2, 2'b10};
    logic        CLK_SYS = 1'b0;
    logic        NRST = 1'b0;
    logic        CE = 1'b1;
    logic [3:0]  ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0000_0000;
    logic        WR = 1'b0;
    logic        RD = 1'b0;
    logic [31:0] RDATA;
    logic        ADC_VALID = 1'b0;
    logic        ADC_READY;
    logic [12:0] ADC_DATA = 13'h0000;
    logic        MEAS_VALID;
    logic [12:0] MEAS_DATA;
    rac_param_t  PARAM;
    logic        POL_VERTICAL;
    logic        TONE_22K;
    logic        NV_WRITE;
    logic [23:0] NV_WDATA;
    logic        NV_VALID;
    logic [23:0] NV_RDATA;
    logic [15:0] lfsr_q = 16'h0050;
    int          fails = 0;
    int          checks_done = 0;
    int          saves = 0;
    int          last_m = 0;
    int          m_ofs, m_gain, m_exp, m_vert, m_band, n, bad;
    bit          chk = 1'b0;
    logic        t;
    int          win[$];
    int          exp_q[$];
    int          exps[5] = '{0, 1, 3, 3, 8};

    rac_top i_rac_top (.CLK_SYS(CLK_SYS), .NRST(NRST), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .ADC_VALID(ADC_VALID), .ADC_READY(ADC_READY), .ADC_DATA(ADC_DATA),
        .MEAS_VALID(MEAS_VALID), .MEAS_DATA(MEAS_DATA), .PARAM(PARAM), .POL_VERTICAL(POL_VERTICAL),
        .TONE_22K(TONE_22K), .NV_WRITE(NV_WRITE), .NV_WDATA(NV_WDATA), .NV_VALID(NV_VALID),
        .NV_RDATA(NV_RDATA));
    rac_nv_model #(.INIT(NV_INIT)) i_rac_nv_model (.clk(CLK_SYS), .nrst(NRST), .nv_write(NV_WRITE),
        .nv_wdata(NV_WDATA), .nv_valid(NV_VALID), .nv_rdata(NV_RDATA));

    always #2 CLK_SYS = ~CLK_SYS;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [22:0] pv();
        return {13'(m_ofs), 4'(m_gain), 4'(m_exp), 1'(m_vert), 1'(m_band)};
    endfunction
    task automatic load(input logic [23:0] w);
        m_ofs = w[22:10];
        m_gain = w[9:6];
        m_exp = w[5:2];
        m_vert = w[1];
        m_band = w[0];
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK_SYS);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge CLK_SYS);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        @(negedge CLK_SYS);
        `CHK(RDATA, e)
    endtask
    task automatic smp(input logic [12:0] d);
        int s;
        @(posedge CLK_SYS);
        ADC_VALID <= 1'b1;
        ADC_DATA <= d;
        @(negedge CLK_SYS);
        while (ADC_READY !== 1'b1) @(negedge CLK_SYS);
        @(posedge CLK_SYS);
        ADC_VALID <= 1'b0;
        win.push_back((d > m_ofs) ? d - m_ofs : 0);
        if (win.size() > (1 << m_exp)) void'(win.pop_front());
        if (win.size() == (1 << m_exp)) begin
            s = 0;
            foreach (win[i]) s += win[i];
            exp_q.push_back(s >> m_exp);
        end
    endtask
    task automatic set_exp(input int e);
        repeat (8) @(posedge CLK_SYS);
        wr(`RAC_REG_EXP, e);
        if (e != m_exp) win.delete();
        m_exp = e;
    endtask
    task automatic reset_and_restore();
        @(posedge CLK_SYS);
        NRST <= 1'b0;
        repeat (10) @(posedge CLK_SYS);
        NRST <= 1'b1;
        repeat (6) @(negedge CLK_SYS);
    endtask
    task automatic results();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(negedge CLK_SYS) if (MEAS_VALID === 1'b1 && chk) begin
        `CHK(exp_q.size() > 0, 1'b1)
        if (exp_q.size() > 0) begin
            last_m = exp_q[0];
            `CHK(MEAS_DATA, 13'(exp_q.pop_front()))
        end
    end
    always @(negedge CLK_SYS) if (NV_WRITE === 1'b1) begin
        saves++;
        `CHK(NV_WDATA, {1'b0, pv()})
    end

    initial begin
        #200000;
        fails++;
        results();
    end

    initial begin
        load(NV_INIT);
        reset_and_restore();
        `CHK(PARAM, pv())
        wr(`RAC_REG_OFS, 32'h0000_0123);
        wr(`RAC_REG_GAIN, 32'h0000_000F);
        wr(`RAC_REG_EXP, 32'h0000_000F);
        wr(`RAC_REG_SEL, 32'h0000_0003);
        m_ofs = 'h123;
        m_gain = 9;
        m_exp = 8;
        m_vert = 1;
        m_band = 1;
        @(negedge CLK_SYS);
        `CHK(PARAM, pv())
        `CHK(POL_VERTICAL, 1'b1)
        rd(`RAC_REG_OFS, 32'h0000_0123);
        rd(`RAC_REG_GAIN, 32'h0000_0009);
        rd(`RAC_REG_EXP, 32'h0000_0008);
        rd(`RAC_REG_SEL, 32'h0000_0003);
        for (int a = 7; a < 16; a++) rd(4'(a), 32'h0000_0000);
        @(posedge CLK_SYS);
        CE <= 1'b0;
        wr(`RAC_REG_GAIN, 32'h0000_0001);
        CE <= 1'b1;
        @(negedge CLK_SYS);
        `CHK(PARAM, pv())
        n = 0;
        t = TONE_22K;
        while (TONE_22K === t) @(negedge CLK_SYS);
        t = TONE_22K;
        while (TONE_22K === t) begin
            @(negedge CLK_SYS);
            n++;
        end
        `CHK(n, `RAC_TONE_HALF)
        wr(`RAC_REG_SEL, 32'h0000_0000);
        m_vert = 0;
        m_band = 0;
        bad = 0;
        repeat (6000) begin
            @(negedge CLK_SYS);
            if (TONE_22K !== 1'b0) bad = 1;
        end
        `CHK(bad, 0)
        `CHK(POL_VERTICAL, 1'b0)
        foreach (exps[i]) begin
            wr(`RAC_REG_CMD, 32'h0000_0001);
            smp(i[0] ? 13'h0800 : 13'h1A00);
            m_ofs = i[0] ? 0 : 'hA00;
            repeat (6) @(negedge CLK_SYS);
            `CHK(PARAM.offset, 13'(m_ofs))
            if (i == 1) break;
        end
        exp_q.delete();
        chk = 1'b1;
        foreach (exps[i]) begin
            set_exp(exps[i]);
            repeat ((1 << exps[i]) + 5) begin
                lfsr_q = lfsr(lfsr_q);
                smp(lfsr_q[0] ? lfsr_q[12:0] : lfsr_q[12:0] >> 1);
            end
        end
        repeat (10) @(negedge CLK_SYS);
        `CHK(exp_q.size(), 0)
        rd(`RAC_REG_MEAS, 32'(last_m));
        rd(`RAC_REG_STAT, 32'h0000_0500);
        `CHK(saves, 0)
        wr(`RAC_REG_CMD, 32'h0000_0002);
        repeat (4) @(negedge CLK_SYS);
        `CHK(saves, 1)
        chk = 1'b0;
        reset_and_restore();
        `CHK(PARAM, pv())
        results();
    end
endmodule
